// File: rtl/fbcfg_defs.svh
// Constants for the fieldbus configuration switch decoder.
// Assumes inclusion by bare name from the rtl folder.
`ifndef FBCFG_DEFS_SVH
`define FBCFG_DEFS_SVH

// Switch field positions (switch n is bit n-1)
`define SW_ENABLE_BIT 7
`define SW_BAUD_HI 6
`define SW_BAUD_LO 5
`define SW_CAN_ADDR_HI 4
`define SW_PB_ADDR_HI 6

// CAN node address range
`define CAN_ADDR_MIN 7'h01
`define CAN_ADDR_MAX 7'h1f
// Slave address valid range on the PROFIBUS module
`define PB_ADDR_MIN 7'h03
`define PB_ADDR_MAX 7'h7d

// Settle time of the switch contacts after reset release
`define SETTLE_NS 1000
`define CLK_NS 50
`define SETTLE_CYC ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// File: rtl/fbcfg_pkg.sv
// Types for the fieldbus configuration switch decoder.
// Assumes no other package.
package fbcfg_pkg;
  typedef enum logic [1:0] {
    BUS_CAN,
    BUS_PROFIBUS,
    BUS_ETHERNET
  } bus_sel_t;

  typedef enum logic [1:0] {
    BAUD_125K = 2'h0,
    BAUD_250K = 2'h1,
    BAUD_500K = 2'h2,
    BAUD_1M = 2'h3
  } can_baud_t;
endpackage

// File: rtl/switch_sampler.sv
// Two-stage synchroniser for the switch contacts and module detection.
// Assumes the pins are quasi-static and come from outside the clock domain.
`timescale 1ns/1ps
module switch_sampler (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Raw pins
  input wire logic [9:0] raw,
  // Synchronised levels
  output logic [9:0] synced
);
  logic [9:0] meta_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= 10'h000;
      synced <= 10'h000;
    end else begin
      meta_q <= raw;
      synced <= meta_q;
    end
  end
endmodule

// File: rtl/fieldbus_config_decoder.sv
// Decodes the eight-position configuration switch into fieldbus settings.
// Assumes static switch and module-presence pins, and a stored parameter
// set that is valid from reset release.
`timescale 1ns/1ps
`include "fbcfg_defs.svh"

//////////////////////////////////////////////////////////////////////////////
// Contract
// - All switches zero: enable, baud and address from stored set; Ethernet enable on.
// - Switches are sampled once after reset; later changes are ignored.
// - No module found: settings go to built-in CAN, else to module.
// - With a non-CAN module present, switches never enable built-in CAN.
// - Switch 8 is communication enable on every bus, 1 on, 0 off.
// - CAN baud from switches 7,6: 11 1M, 10 500k, 01 250k, 00 125k.
// - CAN node address or offset from switches 5..1, range 1 to 31.
// - PROFIBUS address from switches 7..1, valid 3 to 125, baud from master.
// - Ethernet module: all zero brings bus up; switches 7..1 set no address.
// - Ethernet: switches 1..7 nonzero with switch 8 off keeps bus off.
// - Any switch nonzero: switch enable, baud, address override stored set.
// - Effective address is switch value added to stored base node number.
// - Switch-derived address checked and clamped into the allowed range.
// - Bus options such as duplicate node check come from stored set only.
// - Switches never alter the RS485 port settings.
// - Software may re-enable or disable the bus; reset re-applies switches.
module fieldbus_config_decoder
  import fbcfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Switch contacts and module detection (asynchronous pins)
  input wire logic [7:0] switch_in,
  input wire logic module_present,
  input wire logic module_is_ethernet,
  // Stored parameter set
  input wire logic param_enable,
  input wire logic [1:0] param_can_baud,
  input wire logic [6:0] param_base_node,
  input wire logic [6:0] param_addr_offset,
  input wire logic param_dup_node_check,
  input wire logic [7:0] param_rs485_cfg,
  // Run-time override from configuration software
  input wire logic sw_override_valid,
  input wire logic sw_override_enable,
  // Settings towards the fieldbus controllers
  output logic cfg_valid,
  output bus_sel_t bus_select,
  output logic can_enable,
  output can_baud_t can_baud,
  output logic [6:0] can_node_addr,
  output logic can_dup_node_check,
  output logic module_enable,
  output logic [6:0] module_node_addr,
  output logic addr_clamped,
  output logic [7:0] rs485_cfg
);

  //////////////////////////////////////////////////////////////////////////
  // Synchronise pins
  logic [9:0] pins_s;

  switch_sampler u_sampler (
    .clk(clk),
    .sys_rst(sys_rst),
    .raw({module_is_ethernet, module_present, switch_in}),
    .synced(pins_s)
  );

  //////////////////////////////////////////////////////////////////////////
  // Address helpers
  function automatic logic [6:0] clamp7(input logic [7:0] v, input logic [6:0] lo,
                                        input logic [6:0] hi);
    logic [6:0] r;
    r = v[6:0];
    if (v > {1'b0, hi}) begin
      r = hi;
    end else if (v < {1'b0, lo}) begin
      r = lo;
    end
    return r;
  endfunction

  function automatic logic out_of_range(input logic [7:0] v, input logic [6:0] lo,
                                        input logic [6:0] hi);
    return (v > {1'b0, hi}) || (v < {1'b0, lo});
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Sample window: wait for contacts to settle, then capture once
  // A lever still bouncing at capture is latched as it stands; the wait
  // costs a microsecond after reset and buys clean levels
  localparam int unsigned SETTLE = `SETTLE_CYC;
  logic [5:0] settle_q;
  logic taken_q;
  logic take;

  assign take = !taken_q && (settle_q == 6'(SETTLE));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      settle_q <= 6'h00;
    end else if (settle_q != 6'(SETTLE)) begin
      settle_q <= settle_q + 6'h01;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      taken_q <= 1'b0;
    end else if (take) begin
      taken_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Decode of the sampled switch word
  logic [7:0] sw;
  logic sw_zero;
  bus_sel_t bus_d;
  logic en_d;
  can_baud_t baud_d;
  logic [7:0] can_sum;
  logic [7:0] pb_sum;
  logic [6:0] can_addr_d;
  logic [6:0] mod_addr_d;
  logic clamp_d;

  assign sw = pins_s[7:0];
  assign sw_zero = (sw == 8'h00);
  assign can_sum = {1'b0, param_base_node} + (sw_zero ? {1'b0, param_addr_offset}
                   : {3'h0, sw[`SW_CAN_ADDR_HI:0]});
  assign pb_sum = {1'b0, param_base_node} + (sw_zero ? {1'b0, param_addr_offset}
                  : {1'b0, sw[`SW_PB_ADDR_HI:0]});

  always_comb begin
    bus_d = BUS_CAN;
    if (pins_s[8]) begin
      bus_d = pins_s[9] ? BUS_ETHERNET : BUS_PROFIBUS;
    end
  end

  always_comb begin
    // Zero word hands control to the stored set (Ethernet: on), else switch 8 rules
    if (sw_zero) begin
      en_d = (bus_d == BUS_ETHERNET) ? 1'b1 : param_enable;
    end else begin
      en_d = sw[`SW_ENABLE_BIT];
    end
  end

  always_comb begin
    if (sw_zero) begin
      baud_d = can_baud_t'(param_can_baud);
    end else begin
      baud_d = can_baud_t'(sw[`SW_BAUD_HI:`SW_BAUD_LO]);
    end
  end

  always_comb begin
    can_addr_d = clamp7(can_sum, `CAN_ADDR_MIN, `CAN_ADDR_MAX);
    mod_addr_d = clamp7(pb_sum, `PB_ADDR_MIN, `PB_ADDR_MAX);
    clamp_d = 1'b0;
    if (bus_d == BUS_CAN) begin
      clamp_d = out_of_range(can_sum, `CAN_ADDR_MIN, `CAN_ADDR_MAX);
    end else if (bus_d == BUS_PROFIBUS) begin
      clamp_d = out_of_range(pb_sum, `PB_ADDR_MIN, `PB_ADDR_MAX);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Held configuration, captured once per reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_select <= BUS_CAN;
      can_baud <= BAUD_125K;
      can_node_addr <= `CAN_ADDR_MIN;
      module_node_addr <= `PB_ADDR_MIN;
      addr_clamped <= 1'b0;
    end else if (take) begin
      bus_select <= bus_d;
      can_baud <= baud_d;
      can_node_addr <= can_addr_d;
      module_node_addr <= (bus_d == BUS_ETHERNET) ? 7'h00 : mod_addr_d;
      addr_clamped <= clamp_d;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_valid <= 1'b0;
    end else if (take) begin
      cfg_valid <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Enables: switch state until software overrides it at run time
  logic run_en_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_en_q <= 1'b0;
    end else if (take) begin
      run_en_q <= en_d;
    end else if (taken_q && sw_override_valid) begin
      run_en_q <= sw_override_enable;
    end
  end

  // The CAN enable is only ever driven while CAN is the selected bus
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      can_enable <= 1'b0;
      module_enable <= 1'b0;
    end else begin
      can_enable <= (bus_select == BUS_CAN) && taken_q && run_en_q;
      module_enable <= (bus_select != BUS_CAN) && taken_q && run_en_q;
    end
  end

  // Options are passed straight from the stored set, registered
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      can_dup_node_check <= 1'b0;
      rs485_cfg <= 8'h00;
    end else begin
      can_dup_node_check <= param_dup_node_check;
      rs485_cfg <= param_rs485_cfg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  a_sample_once: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_valid |=> $stable(can_baud) && $stable(can_node_addr) && $stable(bus_select))
    else $error("held configuration changed after sample");

  a_can_gated: assert property (@(posedge clk) disable iff (sys_rst)
    (bus_select != BUS_CAN) |-> !can_enable)
    else $error("CAN enabled while a module is selected");

  a_enable_bit: assert property (@(posedge clk) disable iff (sys_rst)
    take && !sw_zero && !sw_override_valid |=> ##1
      (can_enable || module_enable) == $past(sw[`SW_ENABLE_BIT], 2))
    else $error("enable does not follow switch 8");

  a_can_addr_range: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_valid |-> can_node_addr >= 7'h01 && can_node_addr <= 7'h1f)
    else $error("CAN address out of range");

  a_pb_addr_range: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_valid && bus_select == BUS_PROFIBUS |-> module_node_addr inside {[7'h03:7'h7d]})
    else $error("PROFIBUS address out of range");

  a_eth_zero_on: assert property (@(posedge clk) disable iff (sys_rst)
    take && sw_zero && bus_d == BUS_ETHERNET && !sw_override_valid |=> ##1 module_enable)
    else $error("Ethernet not brought up on zero word");

  a_eth_off: assert property (@(posedge clk) disable iff (sys_rst)
    take && bus_d == BUS_ETHERNET && sw[6:0] != 7'h00 && !sw[7] && !sw_override_valid
    |=> ##1 !module_enable)
    else $error("Ethernet on with switch 8 off");

  a_zero_param: assert property (@(posedge clk) disable iff (sys_rst)
    take && sw_zero |=> can_baud == $past(param_can_baud))
    else $error("zero word did not take stored baud");

  a_override: assert property (@(posedge clk) disable iff (sys_rst)
    taken_q && !take && sw_override_valid |=> ##1
      (can_enable || module_enable) == $past(sw_override_enable, 2))
    else $error("software override not applied");

  a_can_baud_sw: assert property (@(posedge clk) disable iff (sys_rst)
    take && !sw_zero |=> can_baud == can_baud_t'($past(sw[`SW_BAUD_HI:`SW_BAUD_LO])))
    else $error("CAN baud does not follow switches 7 and 6");

  a_bus_can_default: assert property (@(posedge clk) disable iff (sys_rst)
    take && !pins_s[8] |=> bus_select == BUS_CAN)
    else $error("built-in CAN not selected without a module");

  a_mod_gated: assert property (@(posedge clk) disable iff (sys_rst)
    (bus_select == BUS_CAN) |-> !module_enable)
    else $error("module enabled while built-in CAN is selected");

  a_zero_enable: assert property (@(posedge clk) disable iff (sys_rst)
    take && sw_zero && bus_d != BUS_ETHERNET && !sw_override_valid |=> ##1
      (can_enable || module_enable) == $past(param_enable, 2))
    else $error("zero word did not take stored enable");

  a_switch_wins: assert property (@(posedge clk) disable iff (sys_rst)
    take && !sw_zero && !sw[`SW_ENABLE_BIT] && param_enable && !sw_override_valid |=> ##1
      !can_enable && !module_enable)
    else $error("stored enable overrode switch 8");

  // Sums are checked where no clamp applied; clamped results have their own checks
  a_zero_addr: assert property (@(posedge clk) disable iff (sys_rst)
    take && sw_zero && bus_d == BUS_CAN && !clamp_d |=>
      can_node_addr == $past(param_base_node) + $past(param_addr_offset))
    else $error("zero word did not take stored address");

  a_can_addr_sum: assert property (@(posedge clk) disable iff (sys_rst)
    take && !sw_zero && bus_d == BUS_CAN && !clamp_d |=>
      can_node_addr == $past(param_base_node) + 7'($past(sw[`SW_CAN_ADDR_HI:0])))
    else $error("CAN address is not base plus switches");

  a_pb_addr_sum: assert property (@(posedge clk) disable iff (sys_rst)
    take && !sw_zero && bus_d == BUS_PROFIBUS && !clamp_d |=>
      module_node_addr == $past(param_base_node) + $past(sw[`SW_PB_ADDR_HI:0]))
    else $error("PROFIBUS address is not base plus switches");

  a_can_clamp_edge: assert property (@(posedge clk) disable iff (sys_rst)
    addr_clamped && bus_select == BUS_CAN |-> can_node_addr inside {7'h01, 7'h1f})
    else $error("clamped CAN address not at a bound");

  a_pb_clamp_edge: assert property (@(posedge clk) disable iff (sys_rst)
    addr_clamped && bus_select == BUS_PROFIBUS |-> module_node_addr inside {7'h03, 7'h7d})
    else $error("clamped PROFIBUS address not at a bound");

  a_eth_addr_zero: assert property (@(posedge clk) disable iff (sys_rst)
    bus_select == BUS_ETHERNET |-> module_node_addr == 7'h00 && !addr_clamped)
    else $error("Ethernet module given a switch address");

  a_dup_option: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> can_dup_node_check == $past(param_dup_node_check))
    else $error("duplicate node option not from stored set");

  a_rs485_copy: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> rs485_cfg == $past(param_rs485_cfg))
    else $error("serial port settings not from stored set");

  a_valid_held: assert property (@(posedge clk) disable iff (sys_rst)
    cfg_valid |=> cfg_valid)
    else $error("configuration valid dropped before reset");

  a_no_early_enable: assert property (@(posedge clk) disable iff (sys_rst)
    !cfg_valid |-> !can_enable && !module_enable)
    else $error("bus enabled before the switch capture");

  a_idle_addr: assert property (@(posedge clk) disable iff (sys_rst)
    !cfg_valid |-> can_node_addr == 7'h01 && module_node_addr == 7'h03)
    else $error("addresses left reset value before capture");

  c_can_on: cover property (@(posedge clk) disable iff (sys_rst) can_enable);
  c_module_on: cover property (@(posedge clk) disable iff (sys_rst) module_enable);
  c_clamped: cover property (@(posedge clk) disable iff (sys_rst) addr_clamped);
  c_override: cover property (@(posedge clk) disable iff (sys_rst)
    taken_q && sw_override_valid);
  c_eth_on: cover property (@(posedge clk) disable iff (sys_rst)
    bus_select == BUS_ETHERNET && module_enable);
endmodule

// File: dv/switch_model.sv
// Behavioural model of the eight-position switch and the module slot.
// Assumes the bench sets the lever positions and the plugged module kind.
`timescale 1ns/1ps
module switch_model
  import fbcfg_pkg::*;
(
  // Requested lever positions and plugged module
  input wire logic [7:0] lever_pos,
  input wire bus_sel_t plug_kind,
  // Contact and detection pins
  output logic [7:0] contact,
  output logic module_present,
  output logic module_is_ethernet
);
  initial contact = 8'h00;

  // Contacts chatter after a lever moves, so early sampling sees wrong levels
  always @(lever_pos) begin
    contact = ~lever_pos;
    #60;
    contact = lever_pos;
  end

  assign module_present = (plug_kind != BUS_CAN);
  assign module_is_ethernet = (plug_kind == BUS_ETHERNET);
endmodule

// File: dv/tb_top.sv
// Self-checking bench for the fieldbus configuration switch decoder.
// Assumes the switch model on the contact pins and a 20 MHz clock.
`timescale 1ns/1ps
module tb_top;
  import fbcfg_pkg::*;
  typedef struct packed {
    logic [7:0] sw;
    bus_sel_t kind;
    logic [6:0] base, off;
    logic pen, can_en;
    logic [1:0] baud;
    logic [6:0] caddr;
    logic mod_en;
    logic [6:0] maddr;
    logic clamp;
  } row_t;

  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [7:0] pos = 8'h00;
  bus_sel_t kind = BUS_CAN;
  logic [6:0] base = 7'h00;
  logic [6:0] off = 7'h00;
  logic pen = 1'h0;
  logic [1:0] pbaud = 2'h1;
  logic dup = 1'h0;
  logic [7:0] rs485 = 8'h00;
  logic ov_valid = 1'h0;
  logic ov_en = 1'h0;
  logic [7:0] sw_pins;
  logic mp, meth, cfg_valid, can_enable, can_dup, module_enable, addr_clamped;
  bus_sel_t bus_select;
  can_baud_t can_baud;
  logic [6:0] can_node_addr, module_node_addr;
  logic [7:0] rs485_cfg;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  // Columns: switches, bus, base, offset, stored enable, then expectations
  row_t rows [13] = '{
    '{8'h00, BUS_CAN, 7'h05, 7'h03, 1'h1, 1'h1, 2'h1, 7'h08, 1'h0, 7'h00, 1'h0},
    '{8'h00, BUS_CAN, 7'h02, 7'h00, 1'h0, 1'h0, 2'h2, 7'h02, 1'h0, 7'h00, 1'h0},
    '{8'he3, BUS_CAN, 7'h00, 7'h00, 1'h0, 1'h1, 2'h3, 7'h03, 1'h0, 7'h00, 1'h0},
    '{8'h80, BUS_CAN, 7'h00, 7'h09, 1'h0, 1'h1, 2'h0, 7'h01, 1'h0, 7'h00, 1'h1},
    '{8'h5f, BUS_CAN, 7'h14, 7'h00, 1'h1, 1'h0, 2'h2, 7'h1f, 1'h0, 7'h00, 1'h1},
    '{8'h21, BUS_CAN, 7'h00, 7'h00, 1'h1, 1'h0, 2'h1, 7'h01, 1'h0, 7'h00, 1'h0},
    '{8'h85, BUS_PROFIBUS, 7'h10, 7'h00, 1'h0, 1'h0, 2'h0, 7'h00, 1'h1, 7'h15, 1'h0},
    '{8'h01, BUS_PROFIBUS, 7'h00, 7'h00, 1'h1, 1'h0, 2'h0, 7'h00, 1'h0, 7'h03, 1'h1},
    '{8'hff, BUS_PROFIBUS, 7'h00, 7'h00, 1'h1, 1'h0, 2'h0, 7'h00, 1'h1, 7'h7d, 1'h1},
    '{8'h00, BUS_PROFIBUS, 7'h0a, 7'h00, 1'h1, 1'h0, 2'h0, 7'h00, 1'h1, 7'h0a, 1'h0},
    '{8'h00, BUS_ETHERNET, 7'h00, 7'h00, 1'h0, 1'h0, 2'h0, 7'h00, 1'h1, 7'h00, 1'h0},
    '{8'h01, BUS_ETHERNET, 7'h00, 7'h00, 1'h1, 1'h0, 2'h0, 7'h00, 1'h0, 7'h00, 1'h0},
    '{8'h80, BUS_ETHERNET, 7'h00, 7'h00, 1'h0, 1'h0, 2'h0, 7'h00, 1'h1, 7'h00, 1'h0}
  };

  switch_model partner (.lever_pos(pos), .plug_kind(kind), .contact(sw_pins),
    .module_present(mp), .module_is_ethernet(meth));

  fieldbus_config_decoder dut (.clk(clk), .sys_rst(sys_rst), .switch_in(sw_pins),
    .module_present(mp), .module_is_ethernet(meth), .param_enable(pen),
    .param_can_baud(pbaud), .param_base_node(base), .param_addr_offset(off),
    .param_dup_node_check(dup), .param_rs485_cfg(rs485),
    .sw_override_valid(ov_valid), .sw_override_enable(ov_en), .cfg_valid(cfg_valid),
    .bus_select(bus_select), .can_enable(can_enable), .can_baud(can_baud),
    .can_node_addr(can_node_addr), .can_dup_node_check(can_dup),
    .module_enable(module_enable), .module_node_addr(module_node_addr),
    .addr_clamped(addr_clamped), .rs485_cfg(rs485_cfg));

  always #25 clk = ~clk;

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Reset with new pins and stored set, then wait well past the capture
  task automatic run_cfg(input row_t r, input int i);
    @(posedge clk);
    sys_rst <= 1'h1;
    pos <= r.sw;
    kind <= r.kind;
    base <= r.base;
    off <= r.off;
    pen <= r.pen;
    pbaud <= 2'(i + 1);
    dup <= i[0];
    rs485 <= 8'h3c + 8'(i);
    repeat (8) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (24) @(posedge clk);
    @(negedge clk);
  endtask

  // One or two back-to-back override pulses, then time for the answer
  task automatic ovr(input logic a, input logic b, input logic two);
    @(posedge clk);
    ov_valid <= 1'h1;
    ov_en <= a;
    if (two) begin
      @(posedge clk);
      ov_en <= b;
    end
    @(posedge clk);
    ov_valid <= 1'h0;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    for (int i = 0; i < 13; i++) begin
      run_cfg(rows[i], i);
      check("cfg_valid", cfg_valid, 8'h01);
      check("bus_select", bus_select, rows[i].kind);
      if (rows[i].kind == BUS_CAN) begin
        check("can_baud", can_baud, rows[i].baud);
        check("can_node_addr", can_node_addr, rows[i].caddr);
      end else begin
        check("module_node_addr", module_node_addr, rows[i].maddr);
      end
      check("can_enable", can_enable, rows[i].can_en);
      check("module_enable", module_enable, rows[i].mod_en);
      check("addr_clamped", addr_clamped, rows[i].clamp);
      check("can_dup_node_check", can_dup, 8'(i % 2));
      check("rs485_cfg", rs485_cfg, 8'h3c + 8'(i));
    end
    // Reset values, and an override before capture must be ignored
    @(posedge clk);
    sys_rst <= 1'h1;
    pos <= 8'he3;
    kind <= BUS_CAN;
    repeat (8) @(posedge clk);
    @(negedge clk);
    check("rst can_node_addr", can_node_addr, 8'h01);
    check("rst module_node_addr", module_node_addr, 8'h03);
    check("rst cfg_valid", cfg_valid, 8'h00);
    @(posedge clk);
    sys_rst <= 1'h0;
    ov_valid <= 1'h1;
    ov_en <= 1'h0;
    @(posedge clk);
    ov_valid <= 1'h0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    check("early cfg_valid", cfg_valid, 8'h00);
    repeat (12) @(posedge clk);
    @(negedge clk);
    check("early override", can_enable, 8'h01);
    // Lever moves after capture stay invisible
    @(posedge clk);
    pos <= 8'h1e;
    repeat (10) @(posedge clk);
    @(negedge clk);
    check("held can_baud", can_baud, 8'h03);
    check("held can_node_addr", can_node_addr, 8'h03);
    ovr(1'h0, 1'h1, 1'h1);
    check("override last wins", can_enable, 8'h01);
    ovr(1'h0, 1'h0, 1'h0);
    check("override off", can_enable, 8'h00);
    run_cfg(rows[2], 2);
    check("reset reapplies", can_enable, 8'h01);
    run_cfg(rows[7], 7);
    ovr(1'h1, 1'h0, 1'h0);
    check("module override", module_enable, 8'h01);
    finish_test();
  end
endmodule
